// >>> hw/legacy_exec_map.vh
`ifndef LEGACY_EXEC_MAP_VH
`define LEGACY_EXEC_MAP_VH

// Opcode patterns, first instruction word
`define OPC_CALL_IND        16'h5634
`define OPC_CALL_ARP_HI     13'h07CD
`define OPC_CALL_CONDITION_FIELD_HI    12'h56E
`define OPC_MAC_HI          8'h84

// Upper 64K program page forced on every target and coefficient address
`define HIGH_PAGE           6'h3F

// Cycle counts per instruction
`define CYC_CALL_IND        4'd7
`define CYC_CALL_ARP        4'd4
`define CYC_CONDITION_FIELD_TAKEN      4'd7
`define CYC_CONDITION_FIELD_FAIL       4'd4

// Condition field codes with side effects
`define CONDITION_FIELD_OV_CLEAR       4'hA
`define CONDITION_FIELD_OV_SET         4'hB

// Saturation limits
`define ACC_MAX_POS         32'h7FFFFFFF
`define ACC_MAX_NEG         32'h80000000

// Reset values
`define PC_RST              22'h3F0000
`define SP_RST              16'h0400
`define ARP_RST             3'h0

`endif

// >>> hw/condition_field_eval.v
`timescale 1ns/1ps
`default_nettype none

// Combinational evaluation of the 4-bit condition field
module condition_field_eval (
  input  wire [3:0] condition_field_in,
  input  wire       zero_in,
  input  wire       neg_in,
  input  wire       carry_in,
  input  wire       ovf_in,
  input  wire       test_flag_in,
  input  wire       branch_input_pin_in,
  output reg        condition_field_true_out
);

  // One term per code; code 1111 is always true
  always @* begin
    case (condition_field_in)
      4'h0: condition_field_true_out = ~zero_in;
      4'h1: condition_field_true_out = zero_in;
      4'h2: condition_field_true_out = ~zero_in & ~neg_in;
      4'h3: condition_field_true_out = ~neg_in;
      4'h4: condition_field_true_out = neg_in;
      4'h5: condition_field_true_out = zero_in | neg_in;
      4'h6: condition_field_true_out = carry_in & ~zero_in;
      4'h7: condition_field_true_out = carry_in;
      4'h8: condition_field_true_out = ~carry_in;
      4'h9: condition_field_true_out = ~carry_in | zero_in;
      4'hA: condition_field_true_out = ~ovf_in;
      4'hB: condition_field_true_out = ovf_in;
      4'hC: condition_field_true_out = ~test_flag_in;
      4'hD: condition_field_true_out = test_flag_in;
      4'hE: condition_field_true_out = ~branch_input_pin_in;
      default: condition_field_true_out = 1'b1;
    endcase
  end

endmodule

`default_nettype wire

// >>> hw/legacy_call_and_mac_exec.v
// How it works
// - Indirect call pushes PC+1, bumps stack, jumps 0x3F:acc_low_half.
// - Call targets and coefficient addresses lie in 0x3F0000-0x3FFFFF.
// - Calls after a repeat prefix clear the repeat count and run once.
// - Pointer call is two words: new pointer in low bits, then target.
// - Pointer call pushes return, bumps stack, jumps 0x3F:immediate.
// - With that jump, in the same cycle, aux_reg_pointer loads the new pointer field.
// - Conditional call is two words: condition low nibble, then target.
// - Taken conditional call pushes PC+2, jumps 0x3F:immediate.
// - Conditional call takes 7 cycles taken, 4 cycles not taken.
// - Codes 0000-0111 test zero, negative and carry combinations.
// - Codes 1000-1111 test carry, overflow, test flag, pin, always.
// - Testing overflow in the conditional call clears overflow flag.
// - MAC is two words, repeatable, N+2 cycles for N runs.
// - Add shifted product, load multiplicand, form signed 16x16 product.
// - Coefficient fetch forces upper six address bits to 0x3F.
// - Zero, negative, carry flags follow the accumulate result.
// - Overflow flag sets on accumulate overflow; only a conditional call testing overflow clears it.
// - Unsaturated overflows step the overflow counter up or down.
// - With saturation, an overflowing sum clamps to the extreme value.
// - Positive shift is logical left, negative is arithmetic right.
// - Repeats bump the coefficient address; any step may set overflow.
`timescale 1ns/1ps
`default_nettype none
`include "legacy_exec_map.vh"

module legacy_call_and_mac_exec #(
  parameter OVC_W = 6,
  parameter RPT_W = 8
) (
  input  wire              mclk_in,
  input  wire              sys_rst_in,
  input  wire              start_in,
  input  wire [15:0]       instr_word0_in,
  input  wire [15:0]       instr_word1_in,
  input  wire              rpt_load_in,
  input  wire [RPT_W-1:0]  rpt_value_in,
  input  wire [3:0]        product_shift_mode_in,
  input  wire              saturate_mode_in,
  input  wire              test_flag_in,
  input  wire              branch_input_pin_in,
  input  wire [21:0]       operand_addr_in,
  input  wire [15:0]       data_rdata_in,
  input  wire [15:0]       prog_rdata_in,
  output reg               busy_out,
  output reg               done_out,
  output reg  [21:0]       pc_out,
  output reg  [15:0]       sp_out,
  output reg  [2:0]        aux_reg_pointer_out,
  output reg  [RPT_W-1:0]  repeat_count_reg_out,
  output reg  [31:0]       accumulator_reg_out,
  output reg  [31:0]       product_out,
  output reg  [15:0]       multiplicand_out,
  output reg               zero_flag_out,
  output reg               neg_flag_out,
  output reg               carry_flag_out,
  output reg               ovf_flag_out,
  output reg  [OVC_W-1:0]  ovf_count_out,
  output reg  [7:0]        operand_locator_out,
  output reg  [21:0]       data_addr_out,
  output reg  [15:0]       data_wdata_out,
  output reg               data_we_out,
  output reg               data_re_out,
  output reg  [21:0]       prog_addr_out,
  output reg               prog_re_out
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CALL = 2'b01;
  localparam [1:0] ST_MAC  = 2'b10;

  reg [1:0]        state;
  reg [3:0]        wait_cnt;
  reg [RPT_W-1:0]  iss_left;
  reg              rd_valid;
  reg              pin_s1;
  reg              pin_s2;
  reg              pin_s3;
  reg              pin_level;

  // Opcode decode of the first word
  wire is_call_ind  = (instr_word0_in == `OPC_CALL_IND);
  wire is_call_arp  = (instr_word0_in[15:3] == `OPC_CALL_ARP_HI);
  wire is_call_condition_field = (instr_word0_in[15:4] == `OPC_CALL_CONDITION_FIELD_HI);
  wire is_mac       = (instr_word0_in[15:8] == `OPC_MAC_HI);
  wire take_start   = start_in & (state == ST_IDLE);
  wire [3:0] condition_field_code = instr_word0_in[3:0];

  // Return addresses: one word past the indirect call, two past the others
  wire [21:0] ret_ind  = pc_out + 22'h000001;
  wire [21:0] ret_long = pc_out + 22'h000002;

  wire condition_field_true;

  condition_field_eval u_condition_field (
    .condition_field_in  (condition_field_code),
    .zero_in             (zero_flag_out),
    .neg_in              (neg_flag_out),
    .carry_in            (carry_flag_out),
    .ovf_in              (ovf_flag_out),
    .test_flag_in        (test_flag_in),
    .branch_input_pin_in (pin_level),
    .condition_field_true_out       (condition_field_true)
  );

  // Pin input passes three flops; a change counts once the last two agree
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_s1    <= 1'b1;
      pin_s2    <= 1'b1;
      pin_s3    <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= branch_input_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // Product shift: signed amount, left fills zeros, right extends sign
  reg [31:0] shifted_p;
  reg [3:0]  neg_amt;
  always @* begin
    neg_amt = 4'h0;
    if (product_shift_mode_in[3]) begin
      neg_amt   = (~product_shift_mode_in) + 4'h1;
      shifted_p = $signed(product_out) >>> neg_amt;
    end else begin
      shifted_p = product_out << product_shift_mode_in;
    end
  end

  // Accumulate adder with overflow detection and optional clamp
  wire [32:0] sum33  = {1'b0, accumulator_reg_out} + {1'b0, shifted_p};
  wire [31:0] sum    = sum33[31:0];
  wire        pos_ov = ~accumulator_reg_out[31] & ~shifted_p[31] & sum[31];
  wire        neg_ov = accumulator_reg_out[31] & shifted_p[31] & ~sum[31];
  reg  [31:0] next_acc;
  always @* begin
    next_acc = sum;
    if (saturate_mode_in & pos_ov) begin
      next_acc = `ACC_MAX_POS;
    end else if (saturate_mode_in & neg_ov) begin
      next_acc = `ACC_MAX_NEG;
    end
  end

  wire signed [31:0] mac_product =
    $signed(data_rdata_in) * $signed(prog_rdata_in);

  // Main sequencer: decode, perform effects, then hold for the cycle count
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state                <= ST_IDLE;
      wait_cnt             <= 4'h0;
      iss_left             <= {RPT_W{1'b0}};
      rd_valid             <= 1'b0;
      busy_out             <= 1'b0;
      done_out             <= 1'b0;
      pc_out               <= `PC_RST;
      sp_out               <= `SP_RST;
      aux_reg_pointer_out  <= `ARP_RST;
      repeat_count_reg_out <= {RPT_W{1'b0}};
      accumulator_reg_out  <= 32'h00000000;
      product_out          <= 32'h00000000;
      multiplicand_out     <= 16'h0000;
      zero_flag_out        <= 1'b0;
      neg_flag_out         <= 1'b0;
      carry_flag_out       <= 1'b0;
      ovf_flag_out         <= 1'b0;
      ovf_count_out        <= {OVC_W{1'b0}};
      operand_locator_out  <= 8'h00;
      data_addr_out        <= 22'h000000;
      data_wdata_out       <= 16'h0000;
      data_we_out          <= 1'b0;
      data_re_out          <= 1'b0;
      prog_addr_out        <= 22'h000000;
      prog_re_out          <= 1'b0;
    end else begin
      done_out    <= 1'b0;
      data_we_out <= 1'b0;
      rd_valid    <= data_re_out;
      case (state)
        ST_IDLE: begin
          // Repeat prefix only loads the count; the next instruction uses it
          if (rpt_load_in & ~start_in) begin
            repeat_count_reg_out <= rpt_value_in;
          end
          if (take_start & is_call_ind) begin
            data_addr_out        <= {6'h00, sp_out};
            data_wdata_out       <= ret_ind[15:0];
            data_we_out          <= 1'b1;
            sp_out               <= sp_out + 16'h0001;
            pc_out <= {`HIGH_PAGE, accumulator_reg_out[15:0]};
            repeat_count_reg_out <= {RPT_W{1'b0}};
            wait_cnt             <= `CYC_CALL_IND - 4'd2;
            state                <= ST_CALL;
            busy_out             <= 1'b1;
          end else if (take_start & is_call_arp) begin
            data_addr_out        <= {6'h00, sp_out};
            data_wdata_out       <= ret_long[15:0];
            data_we_out          <= 1'b1;
            sp_out               <= sp_out + 16'h0001;
            pc_out               <= {`HIGH_PAGE, instr_word1_in};
            aux_reg_pointer_out  <= instr_word0_in[2:0];
            repeat_count_reg_out <= {RPT_W{1'b0}};
            wait_cnt             <= `CYC_CALL_ARP - 4'd2;
            state                <= ST_CALL;
            busy_out             <= 1'b1;
          end else if (take_start & is_call_condition_field) begin
            // Overflow tests clear the flag whether or not the call goes
            if ((condition_field_code == `CONDITION_FIELD_OV_CLEAR) ||
                (condition_field_code == `CONDITION_FIELD_OV_SET)) begin
              ovf_flag_out <= 1'b0;
            end
            if (condition_field_true) begin
              data_addr_out  <= {6'h00, sp_out};
              data_wdata_out <= ret_long[15:0];
              data_we_out    <= 1'b1;
              sp_out         <= sp_out + 16'h0001;
              pc_out         <= {`HIGH_PAGE, instr_word1_in};
              wait_cnt       <= `CYC_CONDITION_FIELD_TAKEN - 4'd2;
            end else begin
              // Stay inside the high page, as a taken call would
              pc_out   <= {`HIGH_PAGE, ret_long[15:0]};
              wait_cnt <= `CYC_CONDITION_FIELD_FAIL - 4'd2;
            end
            repeat_count_reg_out <= {RPT_W{1'b0}};
            state                <= ST_CALL;
            busy_out             <= 1'b1;
          end else if (take_start & is_mac) begin
            // First pair of reads; the rest follow one per cycle
            operand_locator_out  <= instr_word0_in[7:0];
            data_addr_out        <= operand_addr_in;
            data_re_out          <= 1'b1;
            prog_addr_out        <= {`HIGH_PAGE, instr_word1_in};
            prog_re_out          <= 1'b1;
            iss_left             <= repeat_count_reg_out;
            repeat_count_reg_out <= {RPT_W{1'b0}};
            state                <= ST_MAC;
            busy_out             <= 1'b1;
          end else if (take_start) begin
            // Opcodes outside this group finish at once with no effect
            done_out <= 1'b1;
          end
        end
        ST_CALL: begin
          // Pure hold so the call occupies its full cycle count
          if (wait_cnt == 4'h0) begin
            state    <= ST_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        ST_MAC: begin
          // Issue the next pair of reads while repetitions remain
          if (iss_left != {RPT_W{1'b0}}) begin
            iss_left      <= iss_left - {{(RPT_W-1){1'b0}}, 1'b1};
            data_addr_out <= operand_addr_in;
            // Low half wraps inside the high page, never leaving it
            prog_addr_out <= {`HIGH_PAGE,
                              prog_addr_out[15:0] + 16'h0001};
          end else begin
            data_re_out <= 1'b0;
            prog_re_out <= 1'b0;
          end
          // Each returned pair is one accumulate step
          if (rd_valid) begin
            accumulator_reg_out <= next_acc;
            multiplicand_out    <= data_rdata_in;
            product_out         <= mac_product;
            zero_flag_out       <= (next_acc == 32'h00000000);
            neg_flag_out        <= next_acc[31];
            carry_flag_out      <= sum33[32];
            if (pos_ov | neg_ov) begin
              ovf_flag_out <= 1'b1;
            end
            if (~saturate_mode_in & pos_ov) begin
              ovf_count_out <= ovf_count_out + {{(OVC_W-1){1'b0}}, 1'b1};
            end else if (~saturate_mode_in & neg_ov) begin
              ovf_count_out <= ovf_count_out - {{(OVC_W-1){1'b0}}, 1'b1};
            end
            if (~data_re_out) begin
              // Last pair processed: N+2 cycles in all
              pc_out   <= ret_long;
              state    <= ST_IDLE;
              busy_out <= 1'b0;
              done_out <= 1'b1;
            end
          end
        end
        default: begin
          state    <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> dv/unified_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Unified program and data memory with a one-cycle synchronous read
module unified_mem_model (
  input  wire logic        mclk_in,
  input  wire logic [21:0] data_addr_in,
  input  wire logic [15:0] data_wdata_in,
  input  wire logic        data_we_in,
  input  wire logic        data_re_in,
  input  wire logic [21:0] prog_addr_in,
  input  wire logic        prog_re_in,
  output var  logic [15:0] data_rdata_out,
  output var  logic [15:0] prog_rdata_out
);
  logic [15:0] mem [0:4095];
  // Fill formula is shared with the bench's expectations
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'(i * 32'h9E37) ^ 16'hC3A5;
    data_rdata_out = 16'h0000;
    prog_rdata_out = 16'h0000;
  end
  // Idle read lines flip every cycle so stale data never looks valid
  always @(posedge mclk_in) begin
    if (data_we_in) mem[data_addr_in[11:0]] <= data_wdata_in;
    data_rdata_out <= data_re_in ? mem[data_addr_in[11:0]] : ~data_rdata_out;
    prog_rdata_out <= prog_re_in ? mem[prog_addr_in[11:0]] : ~prog_rdata_out;
  end
endmodule
`default_nettype wire

// >>> dv/legacy_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Timing and side-effect checks on the instruction port
module legacy_exec_assertions #(
  parameter RPT_W = 8
) (
  input wire logic             mclk_in,
  input wire logic             sys_rst_in,
  input wire logic             start_in,
  input wire logic [15:0]      instr_word0_in,
  input wire logic             busy_out,
  input wire logic             done_out,
  input wire logic [15:0]      sp_out,
  input wire logic [2:0]       aux_reg_pointer_out,
  input wire logic [RPT_W-1:0] repeat_count_reg_out,
  input wire logic             ovf_flag_out,
  input wire logic [21:0]      data_addr_out,
  input wire logic             data_we_out,
  input wire logic [21:0]      prog_addr_out,
  input wire logic             prog_re_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Accepted first words; only an idle edge takes an instruction
  wire take = start_in && !busy_out;
  wire ind  = take && instr_word0_in == 16'h5634;
  wire ptr  = take && instr_word0_in[15:3] == 13'h07CD;
  wire cnd  = take && instr_word0_in[15:4] == 12'h56E;
  wire vtst = cnd && instr_word0_in[3:1] == 3'b101;
  property p_ind_len; ind |=> busy_out [*6] ##1 done_out; endproperty
  a_ind_len: assert property (p_ind_len) else $error("bad length");
  property p_ptr_len; ptr |=> busy_out [*3] ##1 done_out; endproperty
  a_ptr_len: assert property (p_ptr_len) else $error("bad length");
  property p_cnd_len;
    cnd |-> ##4 (done_out or (busy_out ##3 done_out));
  endproperty
  a_cnd_len: assert property (p_cnd_len) else $error("bad length");
  property p_ptr_ld;
    ptr |=> aux_reg_pointer_out == $past(instr_word0_in[2:0]);
  endproperty
  a_ptr_ld: assert property (p_ptr_ld) else $error("no load");
  property p_cnt_clr;
    ind || ptr || cnd |=> repeat_count_reg_out == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("count kept");
  property p_v_clr; vtst |=> !ovf_flag_out; endproperty
  a_v_clr: assert property (p_v_clr) else $error("overflow kept");
  property p_v_keep; $fell(ovf_flag_out) |-> $past(vtst); endproperty
  a_v_keep: assert property (p_v_keep) else $error("overflow lost");
  // Push goes to the old pointer, pointer ends one word higher
  property p_push;
    data_we_out |-> sp_out == data_addr_out[15:0] + 16'h1
      && data_addr_out[21:16] == 6'h00;
  endproperty
  a_push: assert property (p_push) else $error("bad push");
  property p_coef_pg; prog_re_out |-> prog_addr_out[21:16] == 6'h3F; endproperty
  a_coef_pg: assert property (p_coef_pg) else $error("bad page");
  property p_coef_inc;
    prog_re_out && $past(prog_re_out) |->
      prog_addr_out == $past(prog_addr_out) + 22'h1;
  endproperty
  a_coef_inc: assert property (p_coef_inc) else $error("bad step");
  c_taken: cover property (cnd ##1 data_we_out);
  c_skip: cover property (cnd ##4 done_out);
  c_mac_rep: cover property (prog_re_out [*3]);
endmodule
bind legacy_call_and_mac_exec legacy_exec_assertions #(.RPT_W(RPT_W)) chk (
  .mclk_in, .sys_rst_in, .start_in, .instr_word0_in, .busy_out, .done_out,
  .sp_out, .aux_reg_pointer_out, .repeat_count_reg_out, .ovf_flag_out,
  .data_addr_out, .data_we_out, .prog_addr_out, .prog_re_out);
`default_nettype wire

// >>> dv/legacy_call_and_mac_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module legacy_call_and_mac_exec_tb;
  typedef struct {
    logic [21:0] pc;
    logic [15:0] sp, ret;
    logic [31:0] accum, prod;
    logic [3:0]  flags;
    logic [5:0]  ovc;
    int          due;
    logic [15:0] mult;
    logic [7:0]  loc;
  } exp_t;
  logic        mclk_in, sys_rst_in, start_in, rpt_load_in, saturate_mode_in;
  logic        test_flag_in, branch_input_pin_in, busy_out, done_out;
  logic        zero_flag_out, neg_flag_out, carry_flag_out, ovf_flag_out;
  logic        data_we_out, data_re_out, prog_re_out;
  logic [15:0] instr_word0_in, instr_word1_in, data_rdata_in, prog_rdata_in;
  logic [15:0] sp_out, multiplicand_out, data_wdata_out;
  logic [21:0] operand_addr_in, pc_out, data_addr_out, prog_addr_out;
  logic [31:0] accumulator_reg_out, product_out, seed;
  logic [7:0]  rpt_value_in, repeat_count_reg_out, operand_locator_out;
  logic [3:0]  product_shift_mode_in;
  logic [5:0]  ovf_count_out;
  logic [2:0]  aux_reg_pointer_out;
  int          bad_count, samples_checked, cyc;
  exp_t        st, e, q[$];
  legacy_call_and_mac_exec #(.OVC_W(6), .RPT_W(8)) DUT (.*);
  unified_mem_model mem (.mclk_in, .data_addr_in(data_addr_out),
    .data_wdata_in(data_wdata_out), .data_we_in(data_we_out),
    .data_re_in(data_re_out), .prog_addr_in(prog_addr_out),
    .prog_re_in(prog_re_out), .data_rdata_out(data_rdata_in),
    .prog_rdata_out(prog_rdata_in));
  // Clock, plus an edge count used for latency checks
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] mval(input logic [21:0] a);
    return 16'(a[11:0] * 32'h9E37) ^ 16'hC3A5;
  endfunction
  task automatic check(input logic [31:0] got, want);
    samples_checked++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED %0t mismatch got %h want %h", $time, got, want);
    end
  endtask
  function automatic logic holds(input logic [3:0] cc);
    logic z, n, c, v;
    logic [15:0] t;
    {z, n, c, v} = st.flags;
    t = {1'b1, !branch_input_pin_in, test_flag_in, !test_flag_in, v, !v,
         !c || z, !c, c, c && !z, z || n, n, !n, !z && !n, z, !z};
    return t[cc];
  endfunction
  // A nonzero count is loaded first, which costs one idle cycle
  task automatic issue(input logic [15:0] w0, w1, input logic [7:0] n,
                       input int len);
    int i;
    if (n != 8'h00) begin
      {rpt_value_in, rpt_load_in} = {n, 1'b1};
      @(posedge mclk_in);
      #1 rpt_load_in = 1'b0;
    end
    st.due = cyc + len;
    q.push_back(st);
    {instr_word0_in, instr_word1_in, start_in} = {w0, w1, 1'b1};
    @(posedge mclk_in);
    #1 start_in = 1'b0;
    for (i = 0; i < 60 && done_out !== 1'b1; i++) @(posedge mclk_in) #1;
    // A missing finish counts against the run
    if (done_out !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t finish never came", $time);
    end
  endtask
  task automatic call(input logic [15:0] w0, w1, tgt, input logic tk,
                      input int inc, len, input logic [7:0] n);
    st.ret = 16'(st.pc + 22'(inc));
    st.sp = st.sp + 16'(tk);
    st.pc = tk ? {6'h3F, tgt} : {6'h3F, st.pc[15:0] + 16'h2};
    issue(w0, w1, n, len);
  endtask
  // Models every step of a repeated multiply-accumulate
  task automatic mac(input logic [1:0] reps);
    logic [15:0] w1;
    logic [31:0] sh;
    logic [32:0] s;
    logic        ov;
    int          amt;
    w1 = 16'h0800 | 16'(rnd() & 32'h3FF);
    operand_addr_in = 22'(rnd() & 32'h3FF);
    product_shift_mode_in = 4'(rnd());
    saturate_mode_in = 1'(rnd());
    st.loc = 8'(rnd());
    amt = $signed(product_shift_mode_in);
    for (int k = 0; k <= reps; k++) begin
      if (amt < 0) sh = $signed(st.prod) >>> -amt;
      else sh = st.prod << amt;
      s = {1'b0, st.accum} + {1'b0, sh};
      ov = st.accum[31] == sh[31] && s[31] != sh[31];
      st.accum = s[31:0];
      if (ov && saturate_mode_in)
        st.accum = sh[31] ? 32'h80000000 : 32'h7FFFFFFF;
      if (ov && !saturate_mode_in)
        st.ovc = sh[31] ? st.ovc - 6'h01 : st.ovc + 6'h01;
      st.flags = {st.accum == 32'h0, st.accum[31], s[32], st.flags[0] | ov};
      st.prod = $signed(mval(operand_addr_in))
                * $signed(mval({6'h3F, w1 + 16'(k)}));
    end
    st.pc = st.pc + 22'h2;
    st.mult = mval(operand_addr_in);
    issue({8'h84, st.loc}, w1, {6'h00, reps}, reps + 3);
  endtask
  // Each finished instruction is compared with the oldest note
  always @(negedge mclk_in) begin
    if (!sys_rst_in && data_we_out === 1'b1 && q.size() > 0) begin
      check(data_wdata_out, q[0].ret);
      check(data_addr_out + 22'h1, {6'h00, q[0].sp});
    end
    if (!sys_rst_in && done_out === 1'b1) begin
      e = q.pop_front();
      check(cyc, e.due);
      check(pc_out, e.pc);
      check(sp_out, e.sp);
      check(accumulator_reg_out, e.accum);
      check(product_out, e.prod);
      check({zero_flag_out, neg_flag_out, carry_flag_out, ovf_flag_out},
            e.flags);
      check(ovf_count_out, e.ovc);
      check(repeat_count_reg_out, 32'h0);
      check(multiplicand_out, e.mult);
      check(operand_locator_out, e.loc);
    end
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Far above the expected run of some 1300 cycles
  initial begin
    #200000;
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    results();
  end
  // Each call follows a one-cycle repeat load, codes cycle through all 16
  initial begin
    logic        tk;
    logic [15:0] w;
    logic [7:0]  n;
    {sys_rst_in, start_in, rpt_load_in, saturate_mode_in} = 4'h8;
    {test_flag_in, branch_input_pin_in, instr_word0_in} = 18'h10000;
    {instr_word1_in, operand_addr_in, rpt_value_in} = '0;
    {product_shift_mode_in, bad_count, samples_checked, cyc} = '0;
    seed = 32'h99F7EF31;
    st = '{22'h3F0000, 16'h0400, 16'h0, 32'h0, 32'h0, 4'h0, 6'h0, 0,
           16'h0, 8'h0};
    repeat (20) @(posedge mclk_in);
    #1 sys_rst_in = 1'b0;
    for (int i = 0; i < 48; i++) begin
      {test_flag_in, branch_input_pin_in} = 2'(rnd());
      // Let the pin cross its synchroniser before code 1110 looks at it
      repeat (2) @(posedge mclk_in) #1;
      mac(2'(rnd()));
      tk = holds(4'(i));
      if (i % 16 == 10 || i % 16 == 11) st.flags[0] = 1'b0;
      w = 16'(rnd());
      n = 8'(rnd()) | 8'h01;
      call({12'h56E, 4'(i)}, w, w, tk, 2, tk ? 7 : 4, n);
      w = 16'(rnd());
      call({13'h07CD, w[2:0]}, w, w, 1'b1, 2, 4, n);
      call(16'h5634, w, st.accum[15:0], 1'b1, 1, 7, n);
    end
    // An opcode outside the group finishes at once and changes nothing
    issue(16'h0000, 16'h0000, 8'h00, 1);
    // Let the last finish be compared before the verdict
    @(posedge mclk_in);
    check(q.size(), 0);
    results();
  end
endmodule
`default_nettype wire
